/* File: shared/sadc_pkg.sv */
// Purpose: shared constants for the sampling converter host port
// Assumes: 25 MHz mclk, host strobes synchronous to mclk
// Notes: conversion engine is modelled as a fixed-length timer per channel
package sadc_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int CONV_TIME_NS = 3000;
   localparam int CONV_CYC = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int WAKE_TIME_NS = 5000;
   localparam int WAKE_CYC = (WAKE_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
   // ----------------------------------------------------------------
   // data widths and mode code fields
   // ----------------------------------------------------------------
   localparam int RES_W = 14;
   localparam int MODE_W = 4;
   localparam int MODE_CNT_LSB = 0;
   localparam int MODE_BANK_BIT = 2;
   localparam int MODE_PD_BIT = 3;
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam int NCH = 4;
   localparam int FIFO_DEPTH = 16;
   typedef enum logic [2:0] {
      SADC_IDLE = 3'b001,
      SADC_CONV = 3'b010,
      SADC_WAKE = 3'b100
   } sadc_state_t;
endpackage : sadc_pkg

/* File: rtl/sadc_fifo.sv */
// Purpose: parameterised valid/ready fifo for conversion results
// Assumes: single clock
// Notes: full and empty are exact; no write when full, no read when empty
`timescale 1ns/1ps
module sadc_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sadc_fifo

/* File: rtl/sadc_host_port.sv */
// Purpose: sequencer and parallel host port of a four-track/hold converter
// Assumes: host strobes synchronous to mclk; sample words arrive on sample_data
// Notes: results pass through a fifo into a four-word result memory
`timescale 1ns/1ps
// Contract
// - sampling starts on start strobe rising edge
// - completion flag falls when sequence finishes
// - results are 14-bit words, bit 13 msb
// - low four bus lines shared, bit 0 lsb
// - start strobes ignored while sequence runs
// - reads sequential from channel one, wrapping
// - mode code picks bank, count, power-down
// - mode latched on first of write/select rise
module sadc_host_port
   import sadc_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYC,
   parameter int WAKE_CYCLES = WAKE_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic sample_start_strobe_n,
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic [sadc_pkg::MODE_W-1:0] mode_code_bits_in,
   output logic [sadc_pkg::RES_W-1:0] result_bus_out,
   output logic result_bus_oe,
   output logic done_n,
   output logic hold,
   output logic bank_b_sel,
   output logic power_down,
   output logic [1:0] conv_chan,
   input wire logic [sadc_pkg::RES_W-1:0] sample_data
);
   import sadc_pkg::*;

   // ----------------------------------------------------------------
   // edge detection of host strobes
   // ----------------------------------------------------------------
   logic start_d_r, wr_d_r, cs_d_r, rd_d_r;
   logic start_rise, wr_rise, cs_rise, rd_fall, rd_rise;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         start_d_r <= 1'b1;
         wr_d_r <= 1'b1;
         cs_d_r <= 1'b1;
         rd_d_r <= 1'b1;
      end else begin
         start_d_r <= sample_start_strobe_n;
         wr_d_r <= wr_n;
         cs_d_r <= cs_n;
         rd_d_r <= rd_n;
      end
   end

   assign start_rise = sample_start_strobe_n && !start_d_r;
   assign wr_rise = wr_n && !wr_d_r;
   assign cs_rise = cs_n && !cs_d_r;
   assign rd_fall = !rd_n && rd_d_r && !cs_n;
   assign rd_rise = rd_n && !rd_d_r && !cs_d_r;

   // ----------------------------------------------------------------
   // mode code
   // ----------------------------------------------------------------
   logic [MODE_W-1:0] mode_r;
   logic wr_armed_r;
   logic mode_load;

   // a write window opens with wr low under cs; whichever strobe rises first closes it
   assign mode_load = wr_armed_r && (wr_rise || cs_rise);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_armed_r <= 1'b0;
      end else if (mode_load) begin
         wr_armed_r <= 1'b0;
      end else if (!wr_n && !cs_n) begin
         wr_armed_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_r <= MODE_RST;
      end else if (mode_load) begin
         mode_r <= mode_code_bits_in;
      end
   end

   function automatic logic [1:0] last_chan(input logic [MODE_W-1:0] m);
      return m[MODE_CNT_LSB +: 2];
   endfunction : last_chan

   // ----------------------------------------------------------------
   // conversion sequencer
   // ----------------------------------------------------------------
   sadc_state_t st_r;
   logic [15:0] tmr_r;
   logic [1:0] ch_r;
   logic [1:0] nlast_r;
   logic res_push;
   logic fifo_in_ready;
   logic conv_end;

   assign conv_end = (st_r == SADC_CONV) && (tmr_r == 16'(CONV_CYCLES - 1));
   assign res_push = conv_end && fifo_in_ready;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_r <= SADC_IDLE;
         tmr_r <= '0;
         ch_r <= '0;
         nlast_r <= '0;
      end else begin
         case (st_r)
            SADC_IDLE: begin
               tmr_r <= '0;
               // leaving power-down needs a wake-up delay before sampling
               if (mode_r[MODE_PD_BIT]) begin
                  st_r <= SADC_WAKE;
               end else if (start_rise) begin
                  st_r <= SADC_CONV;
                  ch_r <= '0;
                  nlast_r <= last_chan(mode_r);
               end
            end
            SADC_CONV: begin
               // start strobes are not looked at here
               if (conv_end) begin
                  if (res_push) begin
                     tmr_r <= '0;
                     if (ch_r == nlast_r) begin
                        st_r <= SADC_IDLE;
                     end else begin
                        ch_r <= ch_r + 2'd1;
                     end
                  end
               end else begin
                  tmr_r <= tmr_r + 16'd1;
               end
            end
            SADC_WAKE: begin
               if (mode_r[MODE_PD_BIT]) begin
                  tmr_r <= '0;
               end else if (tmr_r == 16'(WAKE_CYCLES - 1)) begin
                  st_r <= SADC_IDLE;
               end else begin
                  tmr_r <= tmr_r + 16'd1;
               end
            end
            default: st_r <= SADC_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // result path: fifo feeds four-word result memory
   // ----------------------------------------------------------------
   logic [RES_W-1:0] f_data;
   logic f_valid;
   logic [RES_W-1:0] res_mem [NCH];
   logic [1:0] wr_ptr_r;
   logic [1:0] rd_ptr_r;
   logic [1:0] rd_last_r;
   logic seq_done;

   sadc_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .nrst(nrst),
      .in_data(sample_data),
      .in_valid(conv_end),
      .in_ready(fifo_in_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(1'b1)
   );

   // the flag falls only once the last word has landed in memory
   assign seq_done = f_valid && (wr_ptr_r == rd_last_r) && (st_r != SADC_CONV || ch_r != wr_ptr_r);

   always_ff @(posedge mclk) begin
      if (f_valid) begin
         res_mem[wr_ptr_r] <= f_data;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_r <= '0;
         rd_last_r <= '0;
      end else begin
         if (st_r == SADC_IDLE && start_rise && !mode_r[MODE_PD_BIT]) begin
            wr_ptr_r <= '0;
            rd_last_r <= last_chan(mode_r);
         end else if (f_valid) begin
            wr_ptr_r <= wr_ptr_r + 2'd1;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rd_ptr_r <= '0;
      end else if (st_r == SADC_IDLE && start_rise) begin
         rd_ptr_r <= '0;
      end else if (rd_rise) begin
         rd_ptr_r <= (rd_ptr_r == rd_last_r) ? 2'd0 : rd_ptr_r + 2'd1;
      end
   end

   // ----------------------------------------------------------------
   // completion flag and host bus
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         done_n <= 1'b1;
      end else if (seq_done) begin
         done_n <= 1'b0;
      end else if (rd_fall) begin
         done_n <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         result_bus_out <= '0;
         result_bus_oe <= 1'b0;
      end else begin
         result_bus_oe <= !rd_n && !cs_n;
         result_bus_out <= res_mem[rd_ptr_r];
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hold <= 1'b0;
         bank_b_sel <= 1'b0;
         power_down <= 1'b0;
         conv_chan <= '0;
      end else begin
         hold <= (st_r == SADC_CONV);
         bank_b_sel <= mode_r[MODE_BANK_BIT];
         power_down <= mode_r[MODE_PD_BIT];
         conv_chan <= ch_r;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_start_edge: assert property (@(posedge mclk) disable iff (!nrst)
      (st_r == SADC_IDLE && !mode_r[MODE_PD_BIT] && start_rise) |=> st_r == SADC_CONV)
      else $error("rising start strobe did not begin a sequence");
   a_no_fall_start: assert property (@(posedge mclk) disable iff (!nrst)
      (st_r == SADC_IDLE && $fell(sample_start_strobe_n)) |=> st_r != SADC_CONV)
      else $error("falling start strobe began a sequence");
   a_busy_ignore: assert property (@(posedge mclk) disable iff (!nrst)
      (st_r == SADC_CONV && start_rise && !conv_end)
      |=> (st_r == SADC_CONV && $stable(ch_r) && $stable(nlast_r)))
      else $error("start strobe disturbed a running sequence");
   a_done_fall: assert property (@(posedge mclk) disable iff (!nrst)
      seq_done |=> !done_n)
      else $error("completion flag did not fall");
   a_read_wrap: assert property (@(posedge mclk) disable iff (!nrst)
      (rd_rise && rd_ptr_r == rd_last_r && !(st_r == SADC_IDLE && start_rise))
      |=> rd_ptr_r == 2'd0)
      else $error("read pointer did not wrap to channel one");
   a_mode_load: assert property (@(posedge mclk) disable iff (!nrst)
      mode_load |=> mode_r == $past(mode_code_bits_in))
      else $error("mode code not latched");
   a_bank_sel: assert property (@(posedge mclk) disable iff (!nrst)
      ##1 bank_b_sel == $past(mode_r[MODE_BANK_BIT]))
      else $error("bank select does not follow mode");
   a_bus_drive: assert property (@(posedge mclk) disable iff (!nrst)
      (!rd_n && !cs_n) |=> result_bus_oe)
      else $error("result bus not driven during read");
endmodule : sadc_host_port

/* File: tb/sadc_host_model.sv */
// Purpose: behavioural host driving select, write, read and start strobes
// Assumes: strobes change by nonblocking assignment on the mclk rising edge
// Notes: the shared low lines are driven by the host only during a write
`timescale 1ns/1ps
module sadc_host_model (
   input wire logic mclk,
   input wire logic [13:0] bus_in,
   input wire logic bus_oe,
   output logic cs_n,
   output logic wr_n,
   output logic rd_n,
   output logic start_n,
   output logic [3:0] host_bits,
   output logic host_oe
);
   initial begin
      cs_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      start_n = 1'b1;
      host_bits = 4'h0;
      host_oe = 1'b0;
   end

   // ----------------------------------------------------------------
   // bus cycles
   // ----------------------------------------------------------------
   task automatic write_mode(input logic [3:0] code, input bit by_cs);
      @(posedge mclk);
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      host_oe <= 1'b1;
      host_bits <= code;
      @(posedge mclk);
      // either strobe may end the write, data still held on that edge
      if (by_cs) begin
         cs_n <= 1'b1;
      end else begin
         wr_n <= 1'b1;
      end
      @(posedge mclk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      host_oe <= 1'b0;
   endtask : write_mode

   task automatic pulse_start(input int low_cyc);
      @(posedge mclk);
      start_n <= 1'b0;
      repeat (low_cyc) @(posedge mclk);
      start_n <= 1'b1;
   endtask : pulse_start

   task automatic read_word(output logic [13:0] w, output logic oe);
      @(posedge mclk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      w = bus_in;
      oe = bus_oe;
      @(posedge mclk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      // two idle cycles keep the gap between reads well above 40 ns
      @(posedge mclk);
   endtask : read_word
endmodule : sadc_host_model

/* File: tb/simultaneous_adc_host_port_tb.sv */
// Purpose: self-checking bench for the converter host port
// Assumes: 25 MHz mclk, shortened conversion and wake counts
// Notes: converter words come from a random table indexed by conv_chan
`timescale 1ns/1ps
module simultaneous_adc_host_port_tb;
   import sadc_pkg::*;
   localparam int CONV_T = 8;
   localparam int WAKE_T = 2;
   logic mclk, nrst, cs_n, wr_n, rd_n, start_n, host_oe;
   logic result_bus_oe, done_n, hold, bank_b_sel, power_down;
   logic [3:0] host_bits, low_lines;
   logic [3:0] idle_pat = 4'h5;
   logic [1:0] conv_chan;
   logic [13:0] result_bus_out;
   logic [13:0] sample_data = 14'h0;
   logic [13:0] tbl [4];
   logic [31:0] seed;
   int miscompares, cmp_count;
   int cyc = 0;

   // ----------------------------------------------------------------
   // clock, wire resolution, converter stand-in
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // released lines wander so a stale value can never pass for data
   assign low_lines = result_bus_oe ? result_bus_out[3:0] : (host_oe ? host_bits : idle_pat);
   always @(posedge mclk) begin
      idle_pat <= ~idle_pat;
      sample_data <= tbl[conv_chan];
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares = miscompares + 1;
         report_and_stop();
      end
   end

   sadc_host_port #(.CONV_CYCLES(CONV_T), .WAKE_CYCLES(WAKE_T)) u_sadc_host_port (
      .mclk(mclk), .nrst(nrst), .sample_start_strobe_n(start_n), .cs_n(cs_n),
      .wr_n(wr_n), .rd_n(rd_n), .mode_code_bits_in(low_lines),
      .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe), .done_n(done_n),
      .hold(hold), .bank_b_sel(bank_b_sel), .power_down(power_down),
      .conv_chan(conv_chan), .sample_data(sample_data));

   sadc_host_model u_sadc_host_model (
      .mclk(mclk), .bus_in(result_bus_out), .bus_oe(result_bus_oe), .cs_n(cs_n),
      .wr_n(wr_n), .rd_n(rd_n), .start_n(start_n), .host_bits(host_bits),
      .host_oe(host_oe));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic check(input logic [13:0] seen, input logic [13:0] exp, input string what);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic run_seq(input logic [3:0] code, input bit extra);
      int n;
      int c;
      logic [31:0] r;
      logic [13:0] w;
      logic [13:0] w_exp;
      logic [13:0] exp_q [$];
      logic oe;
      n = int'(code[1:0]) + 1;
      for (int i = 0; i < 4; i++) begin
         r = xs();
         tbl[i] = r[13:0];
         if (i < n) begin
            exp_q.push_back(r[13:0]);
         end
      end
      u_sadc_host_model.pulse_start(4);
      #1;
      check(14'(hold), 14'h0, "hold on falling strobe");
      c = 0;
      if (extra) begin
         // the extra strobe's rise is seen on the first cycle of channel two, just after channel one ends
         repeat (6) @(posedge mclk);
         u_sadc_host_model.pulse_start(2);
         #1;
         c = 9;
      end
      while (done_n !== 1'b0 && c < 300) begin
         @(posedge mclk);
         #1;
         c = c + 1;
         if (c == 4) begin
            check(14'(hold), 14'h1, "hold while converting");
         end
      end
      check(14'(c >= n * CONV_T && c <= n * CONV_T + 8), 14'h1, "sequence length");
      for (int k = 0; k <= n; k++) begin
         u_sadc_host_model.read_word(w, oe);
         w_exp = exp_q.pop_front();
         exp_q.push_back(w_exp);
         check(w, w_exp, "read word");
         check(14'(oe), 14'h1, "bus drive");
         check(14'(done_n), 14'h1, "flag cleared by read");
      end
   endtask : run_seq

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] r;
      nrst = 1'b0;
      seed = 32'ha9114f67;
      for (int i = 0; i < 4; i++) tbl[i] = 14'h0;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      #1;
      check(14'({bank_b_sel, power_down, done_n}), 14'h1, "reset outputs");
      run_seq(MODE_RST, 1'b0);
      for (int m = 0; m < 8; m++) begin
         r = xs();
         u_sadc_host_model.write_mode(4'(m), r[0]);
         repeat (3) @(posedge mclk);
         #1;
         check(14'({bank_b_sel, power_down}), 14'({m[2], 1'b0}), "mode bits");
         run_seq(4'(m), m[1:0] == 2'b11);
      end
      r = xs();
      u_sadc_host_model.write_mode({1'b1, r[2:0]}, r[3]);
      repeat (3) @(posedge mclk);
      #1;
      check(14'(power_down), 14'h1, "power down");
      u_sadc_host_model.pulse_start(2);
      repeat (40) @(posedge mclk);
      #1;
      check(14'({hold, done_n}), 14'h1, "start while powered down");
      u_sadc_host_model.write_mode(4'h3, 1'b0);
      repeat (WAKE_T + 6) @(posedge mclk);
      run_seq(4'h3, 1'b0);
      report_and_stop();
   end
endmodule : simultaneous_adc_host_port_tb
